/* File: common/port_io_pkg.sv */
// Package for the eight-pin general-purpose port block.
// Assumes a byte-wide register port and one 100 MHz clock domain.
package port_io_pkg;

	// Register indices on the plain register port
	localparam logic [2:0] ADDR_DATA      = 3'h0;
	localparam logic [2:0] ADDR_DIRECTION = 3'h1;
	localparam logic [2:0] ADDR_PULL      = 3'h2;
	localparam logic [2:0] ADDR_SLEW      = 3'h3;
	localparam logic [2:0] ADDR_DRIVE     = 3'h4;
	localparam logic [2:0] ADDR_LAST      = 3'h4;

	// Reset values
	localparam logic [7:0] RST_DATA      = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] RST_PULL      = 8'h00;
	localparam logic [7:0] RST_SLEW      = 8'h00;
	localparam logic [7:0] RST_DRIVE     = 8'h00;

	// Bit position of the input-only pin
	localparam int INPUT_ONLY_BIT = 1;

	// Per-pin electrical controls to the pad ring
	typedef struct packed {
		logic [7:0] pin_out;     // Level driven on the pin
		logic [7:0] pin_oe_n;    // Low while the pin is driven
		logic [7:0] pull_up;     // Internal pull-up on
		logic [7:0] pull_down;   // Internal pull-down on
		logic [7:0] slew_on;     // Output slew control on
		logic [7:0] drive_high;  // High drive strength
	} pad_ctrl_t;

endpackage

/* File: hdl/port_reg_bank.sv */
// Small register bank holding the port's control bytes.
// Assumes one writer; read data registered one cycle after the strobe.
`timescale 1ns/1ps
module port_reg_bank #(
	parameter int DEPTH = 5
) (
	input  wire logic       sys_clk,   // System clock
	input  wire logic       nrst,      // Async reset, active low
	input  wire logic       wr_en,     // Write strobe
	input  wire logic [2:0] wr_addr,   // Write index
	input  wire logic [7:0] wr_data,   // Write data
	input  wire logic [2:0] rd_addr,   // Read index
	output logic      [7:0] rd_data,   // Registered read data
	output logic      [7:0] word_0,    // Current stored words
	output logic      [7:0] word_1,    // Direction
	output logic      [7:0] word_2,    // Pull
	output logic      [7:0] word_3,    // Slew
	output logic      [7:0] word_4     // Drive
);

	logic [7:0] mem_r   [DEPTH];
	logic [7:0] mem_nxt [DEPTH];
	logic [7:0] rd_data_nxt;

	function automatic logic [7:0] reset_word(input int idx);
		case (idx)
			0:       reset_word = port_io_pkg::RST_DATA;
			1:       reset_word = port_io_pkg::RST_DIRECTION;
			2:       reset_word = port_io_pkg::RST_PULL;
			3:       reset_word = port_io_pkg::RST_SLEW;
			default: reset_word = port_io_pkg::RST_DRIVE;
		endcase
	endfunction

	// Next state: one word written per strobe, all eight bits
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
			if (wr_en && (int'(wr_addr) == i)) begin
				mem_nxt[i] = wr_data;
			end
		end
		rd_data_nxt = 8'h00;
		if (int'(rd_addr) < DEPTH) begin
			rd_data_nxt = mem_r[rd_addr];
		end
	end

	// Registers only
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= reset_word(i);
			end
			rd_data <= 8'h00;
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
			rd_data <= rd_data_nxt;
		end
	end

	assign word_0 = mem_r[0];
	assign word_1 = mem_r[1];
	assign word_2 = mem_r[2];
	assign word_3 = mem_r[3];
	assign word_4 = mem_r[4];

endmodule // port_reg_bank

/* File: hdl/port_io_ctrl.sv */
// Eight-pin general-purpose port: data latch, direction, pull, slew, drive.
// Assumes synchronous pin inputs, a byte register port, one clock domain.
//
// Function
// - Input pins read back the sampled pin level.
// - Output pins read back the data latch value.
// - Data writes store all eight bits, inputs included.
// - Output pins drive their latched data bit.
// - Reset clears latch and controls; all pins undriven inputs, no pull.
// - Data bit 1 always reads the pin level.
// - Direction 0 is input, driver off; 1 is output, driver on.
// - Pin 1 direction, slew and drive bits store but do nothing.
// - Pull enable 0 turns pull-up off, 1 turns it on for input pins only.
// - Pull-downs only with interrupt edge/pin select; otherwise pull-up.
// - Slew bit enables slew control, ignored on input pins.
// - Drive bit selects high drive, ignored on input pins.
`timescale 1ns/1ps
module port_io_ctrl (
	input  wire logic       sys_clk,      // System clock, 100 MHz
	input  wire logic       nrst,         // Async reset, active low
	input  wire logic [2:0] reg_addr,     // Register index
	input  wire logic [7:0] reg_wdata,    // Write data
	input  wire logic       reg_wr,       // Write strobe
	input  wire logic       reg_rd,       // Read strobe
	output logic      [7:0] reg_rdata,    // Read data, cycle after strobe
	input  wire logic [7:0] pin_in,       // Sampled pin levels
	input  wire logic [7:0] irq_pin_sel,  // Pin interrupt select bits
	input  wire logic [7:0] irq_edge_sel, // Edge select, 1 = rising
	output port_io_pkg::pad_ctrl_t pad    // Pad controls, all registered
);

	////////////////////////////////////////////////////////////////////////
	// Control storage

	logic [7:0] pin_data_latch;
	logic [7:0] pin_direction_bits;
	logic [7:0] pull_enable_bits;
	logic [7:0] slew_control_bits;
	logic [7:0] drive_select_bits;
	logic [7:0] bank_rdata;

	// Write every strobe; read index held separately for the pin mux
	port_reg_bank #(
		.DEPTH (5)
	) u_bank (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.wr_en   (reg_wr),
		.wr_addr (reg_addr),
		.wr_data (reg_wdata),
		.rd_addr (reg_addr),
		.rd_data (bank_rdata),
		.word_0  (pin_data_latch),
		.word_1  (pin_direction_bits),
		.word_2  (pull_enable_bits),
		.word_3  (slew_control_bits),
		.word_4  (drive_select_bits)
	);

	// Usable direction: pin 1 can never be an output
	function automatic logic [7:0] eff_dir(input logic [7:0] dir);
		logic [7:0] d;
		d = dir;
		d[port_io_pkg::INPUT_ONLY_BIT] = 1'b0;
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Read path

	typedef enum logic [1:0] {
		RD_NONE = 2'b00,
		RD_DATA = 2'b01,
		RD_BANK = 2'b10
	} rd_sel_t;

	rd_sel_t    rd_sel_r, rd_sel_nxt;
	logic [7:0] pin_snap_r, pin_snap_nxt;
	logic [7:0] dir_snap_r, dir_snap_nxt;
	logic [7:0] reg_rdata_nxt;

	// Snapshot pin and direction at the strobe so data matches bank timing
	always_comb begin
		rd_sel_nxt   = RD_NONE;
		pin_snap_nxt = pin_in;
		dir_snap_nxt = eff_dir(pin_direction_bits);
		if (reg_rd && reg_addr == port_io_pkg::ADDR_DATA) begin
			rd_sel_nxt = RD_DATA;
		end else if (reg_rd && reg_addr <= port_io_pkg::ADDR_LAST) begin
			rd_sel_nxt = RD_BANK;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_sel_r   <= RD_NONE;
			pin_snap_r <= 8'h00;
			dir_snap_r <= 8'h00;
		end else begin
			rd_sel_r   <= rd_sel_nxt;
			pin_snap_r <= pin_snap_nxt;
			dir_snap_r <= dir_snap_nxt;
		end
	end

	// Pin where input, latch where output; unmapped reads return zero
	always_comb begin
		case (rd_sel_r)
			RD_DATA: reg_rdata_nxt = (pin_snap_r & ~dir_snap_r)
			                       | (bank_rdata & dir_snap_r);
			RD_BANK: reg_rdata_nxt = bank_rdata;
			default: reg_rdata_nxt = 8'h00;
		endcase
	end
	// Combinational after the bank's read flop: output is still flop-fed
	assign reg_rdata = reg_rdata_nxt;

	////////////////////////////////////////////////////////////////////////
	// Pad controls

	port_io_pkg::pad_ctrl_t pad_nxt;
	logic [7:0]             dir_eff;
	logic [7:0]             pulls;

	// Pull only on inputs; pin select and edge select together pick the direction of the pull
	always_comb begin
		dir_eff            = eff_dir(pin_direction_bits);
		pulls              = pull_enable_bits & ~dir_eff;
		pad_nxt.pin_out    = pin_data_latch & dir_eff;
		pad_nxt.pin_oe_n   = ~dir_eff;
		pad_nxt.pull_down  = pulls & irq_pin_sel & irq_edge_sel;
		pad_nxt.pull_up    = pulls & ~(irq_pin_sel & irq_edge_sel);
		pad_nxt.slew_on    = slew_control_bits & dir_eff;
		pad_nxt.drive_high = drive_select_bits & dir_eff;
	end

	// Reset leaves every pin undriven with no pull
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pad <= '{pin_out: 8'h00, pin_oe_n: 8'hff,
			         pull_up: 8'h00, pull_down: 8'h00,
			         slew_on: 8'h00, drive_high: 8'h00};
		end else begin
			pad <= pad_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_pin1_never_driven: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		pad.pin_oe_n[port_io_pkg::INPUT_ONLY_BIT] &&
		!pad.slew_on[port_io_pkg::INPUT_ONLY_BIT] &&
		!pad.drive_high[port_io_pkg::INPUT_ONLY_BIT])
		else $error("input-only pin shows output controls");

	a_drive_follows_latch: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		##1 (pad.pin_out == ($past(pin_data_latch)
		                     & $past(dir_eff))))
		else $error("driven level differs from latch");

	a_oe_follows_dir: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		##1 (pad.pin_oe_n == ~$past(eff_dir(pin_direction_bits))))
		else $error("output enable differs from direction");

	a_no_pull_output: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		((pad.pull_up | pad.pull_down) & ~pad.pin_oe_n) == 8'h00)
		else $error("pull active on an output pin");

	a_pull_on_input: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		##1 ((pad.pull_up ^ ($past(pull_enable_bits)
		      & ~$past(eff_dir(pin_direction_bits))
		      & ~($past(irq_pin_sel) & $past(irq_edge_sel))))
		     == 8'h00))
		else $error("enabled pull-up not applied");

	a_pull_down_sel: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		##1 ((pad.pull_down & ~($past(irq_pin_sel)
		                        & $past(irq_edge_sel))) == 8'h00))
		else $error("pull-down without interrupt selection");

	a_slew_input_off: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(pad.slew_on & pad.pin_oe_n) == 8'h00)
		else $error("slew control active on an input pin");

	a_drive_input_off: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(pad.drive_high & pad.pin_oe_n) == 8'h00)
		else $error("high drive active on an input pin");

	a_ctrl_readback: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		reg_wr && reg_addr == port_io_pkg::ADDR_SLEW ##1
		reg_rd && reg_addr == port_io_pkg::ADDR_SLEW && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("control register readback mismatch");

	a_data_all_bits: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		reg_wr && reg_addr == port_io_pkg::ADDR_DATA
		|=> pin_data_latch == $past(reg_wdata))
		else $error("data latch did not store all bits");

	a_input_reads_pin: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		reg_rd && reg_addr == port_io_pkg::ADDR_DATA
		|=> ((reg_rdata ^ $past(pin_in)) & ~$past(eff_dir(
		     pin_direction_bits))) == 8'h00)
		else $error("input pin read does not show pin level");

	a_bit1_reads_pin: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		reg_rd && reg_addr == port_io_pkg::ADDR_DATA
		|=> reg_rdata[1] == $past(pin_in[1]))
		else $error("bit one read does not show pin level");

	a_output_reads_latch: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		reg_rd && reg_addr == port_io_pkg::ADDR_DATA && !reg_wr
		|=> ((reg_rdata ^ pin_data_latch) & $past(eff_dir(
		     pin_direction_bits))) == 8'h00)
		else $error("output pin read does not show latch");

	a_reset_state: assert property (
		@(posedge sys_clk)
		$rose(nrst) |-> pad.pin_oe_n == 8'hff && pad.pull_up == 8'h00
		                && pin_data_latch == 8'h00)
		else $error("reset did not leave pins undriven");

endmodule // port_io_ctrl

/* File: tb/board_model.sv */
// Board-side model of the eight port pins.
// Assumes registered pad controls and bench-set external drivers.
`timescale 1ns/1ps
module board_model (
	input  wire logic                   sys_clk, // System clock
	input  wire port_io_pkg::pad_ctrl_t pad,     // Pad controls
	input  wire logic [7:0]             ext_en,  // External driver on
	input  wire logic [7:0]             ext_val, // External level
	output logic      [7:0]             pin_in   // Resolved pin levels
);
	logic [7:0] float_r = 8'h55; // Level of undriven lines

	////////////////////////////////////////////////////////////////////////
	// Undriven lines toggle, so no stale level can pass for a match
	always_ff @(posedge sys_clk) begin
		float_r <= ~float_r;
	end

	// Device driver wins, then board driver, then the pulls
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad.pin_oe_n[i])
				pin_in[i] = pad.pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pad.pull_up[i])
				pin_in[i] = 1'b1;
			else if (pad.pull_down[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = float_r[i];
		end
	end
endmodule // board_model

/* File: tb/tb_port_io_ctrl.sv */
// Self-checking bench for the eight-pin port block.
// Assumes the board model on the pins and a plain register port.
`timescale 1ns/1ps
module tb_port_io_ctrl;
	logic                   sys_clk = 1'b0;
	logic                   nrst = 1'b0;
	logic [2:0]             reg_addr = 3'h0;
	logic [7:0]             reg_wdata = 8'h00;
	logic                   reg_wr = 1'b0;
	logic                   reg_rd = 1'b0;
	logic [7:0]             reg_rdata;
	logic [7:0]             pin_in;
	logic [7:0]             irq_pin_sel = 8'h00;
	logic [7:0]             irq_edge_sel = 8'h00;
	logic [7:0]             ext_en = 8'hff;
	logic [7:0]             ext_val = 8'h00;
	logic [7:0]             rv;
	port_io_pkg::pad_ctrl_t pad;
	int                     error_cnt = 0;
	int                     check_count = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #5 sys_clk = ~sys_clk;

	port_io_ctrl port_io_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
		.irq_pin_sel(irq_pin_sel), .irq_edge_sel(irq_edge_sel),
		.pad(pad));

	board_model board_model_inst (.sys_clk(sys_clk), .pad(pad),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	////////////////////////////////////////////////////////////////////////
	// Bus cycles and comparison
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Strobe taken at the second edge; data stands just after that same edge
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Write then read the same index with no gap between strobes
	task automatic wr_rd(input logic [2:0] a, input logic [7:0] d,
	                     output logic [7:0] q);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask

	// Pads follow registers one cycle later
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		repeat (5) @(posedge sys_clk);
		#1;
		check(pad.pin_oe_n, 8'hff);
		check(pad.pull_up, 8'h00);
		@(posedge sys_clk);
		nrst <= 1'b1;
		for (int a = 0; a < 5; a++) begin
			rd(a[2:0], rv);
			check(rv, 8'h00);
		end
	endtask

	// Control bytes read back; unmapped index refused
	task automatic t_regs;
		logic [7:0] v [4] = '{8'h3c, 8'ha5, 8'h96, 8'h69};
		for (int a = 1; a < 5; a++) wr(a[2:0], v[a-1]);
		wr(3'h5, 8'hff);
		rd(3'h5, rv);
		check(rv, 8'h00);
		for (int a = 1; a < 5; a++) begin
			rd(a[2:0], rv);
			check(rv, v[a-1]);
		end
		for (int a = 1; a < 5; a++) wr(a[2:0], 8'h00);
	endtask

	// Mixed directions; latch keeps bits written while input
	task automatic t_data;
		ext_val <= 8'h3e;
		wr(port_io_pkg::ADDR_DIRECTION, 8'hf0);
		wr(port_io_pkg::ADDR_DATA, 8'ha5);
		settle();
		check(pad.pin_oe_n, 8'h0f);
		check(pad.pin_out & 8'hf0, 8'ha0);
		rd(port_io_pkg::ADDR_DATA, rv);
		check(rv, 8'hae);
		wr(port_io_pkg::ADDR_DIRECTION, 8'h0f);
		settle();
		check(pad.pin_oe_n, 8'hf2);
		check(pad.pin_out & 8'h0d, 8'h05);
		rd(port_io_pkg::ADDR_DATA, rv);
		check(rv, 8'h37);
	endtask

	// Slew and drive only on real outputs
	task automatic t_slew;
		wr(port_io_pkg::ADDR_DIRECTION, 8'hff);
		wr_rd(port_io_pkg::ADDR_SLEW, 8'hff, rv);
		check(rv, 8'hff);
		wr(port_io_pkg::ADDR_DRIVE, 8'hff);
		settle();
		check(pad.pin_oe_n, 8'h02);
		check(pad.slew_on, 8'hfd);
		check(pad.drive_high, 8'hfd);
		wr(port_io_pkg::ADDR_DIRECTION, 8'h00);
		settle();
		check(pad.slew_on, 8'h00);
		check(pad.drive_high, 8'h00);
	endtask

	// Pulls on inputs only; pull-down with interrupt selection
	task automatic t_pull;
		ext_en <= 8'h00;
		irq_pin_sel <= 8'h30;
		irq_edge_sel <= 8'h10;
		wr(port_io_pkg::ADDR_DIRECTION, 8'h0f);
		wr(port_io_pkg::ADDR_PULL, 8'hff);
		settle();
		check(pad.pull_up, 8'he2);
		check(pad.pull_down, 8'h10);
		rd(port_io_pkg::ADDR_DATA, rv);
		check(rv, 8'he7);
		wr(port_io_pkg::ADDR_PULL, 8'h00);
		settle();
		check(pad.pull_up | pad.pull_down, 8'h00);
		ext_en <= 8'hff;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard
	initial begin
		t_reset();
		t_regs();
		t_data();
		t_slew();
		t_pull();
		print_verdict();
	end

	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
endmodule // tb_port_io_ctrl
